/* common/mbind_defines.svh */
// timing counts and display message codes for the meter binding control
`ifndef MBIND_DEFINES_SVH
`define MBIND_DEFINES_SVH
`define MBIND_CLK_HZ 40000000
`define MBIND_ENTER_MS 2000
`define MBIND_NORES_MS 2000
`define MBIND_TIMEOUT_MIN 30
`define MBIND_ENTER_CYC ((`MBIND_CLK_HZ / 1000) * `MBIND_ENTER_MS)
`define MBIND_NORES_CYC ((`MBIND_CLK_HZ / 1000) * `MBIND_NORES_MS)
`define MBIND_TIMEOUT_CYC (64'd60 * `MBIND_TIMEOUT_MIN * `MBIND_CLK_HZ)
`define MBIND_BLINK_CYC 20000000
`define MBIND_NCHAN 4
`define MBIND_MSG_NONE 4'h0
`define MBIND_MSG_NORES 4'h1
`define MBIND_MSG_LIST 4'h2
`define MBIND_MSG_BOUND 4'h3
`define MBIND_MSG_BIND 4'h4
`define MBIND_MSG_CHAN 4'h5
`define MBIND_MSG_DEINST 4'h6
`endif

/* common/mbind_pkg.sv */
// types for the meter binding control
package mbind_pkg;
  typedef enum logic [1:0] {MBIND_PR_NONE, MBIND_PR_SHORT, MBIND_PR_LONG, MBIND_PR_XLONG} mbind_press_t;
  typedef enum logic [1:0] {MBIND_HINT_NONE, MBIND_HINT_ENTER, MBIND_HINT_ESC} mbind_hint_t;
  typedef struct packed {
    logic [31:0] ident;
    logic [15:0] manuf;
    logic [7:0] version;
    logic [7:0] dev_type;
  } mbind_short_id_t;
  typedef struct packed {
    logic valid;
    logic bidir;
    logic bound_elsewhere;
    mbind_short_id_t id;
  } mbind_cand_t;
endpackage

/* src/mbind_ctrl.sv */
// binding/deinstall control for up to four wireless metering devices
`timescale 1ns/1ps
`include "mbind_defines.svh"
module mbind_ctrl
  import mbind_pkg::*;
#(
  parameter logic [31:0] ENTER_CYC = `MBIND_ENTER_CYC,
  parameter logic [31:0] NORES_CYC = `MBIND_NORES_CYC,
  parameter logic [36:0] TIMEOUT_CYC = 37'(`MBIND_TIMEOUT_CYC),
  parameter logic [31:0] BLINK_CYC = `MBIND_BLINK_CYC
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic bind_button,
  input wire logic display_touch,
  input wire mbind_cand_t cand,
  input wire logic snd_ir,
  input wire logic snd_nr,
  input wire logic tool_install,
  input wire mbind_short_id_t tool_id,
  input wire logic tool_uninstall,
  input wire logic [1:0] tool_chan,
  input wire logic deinst_sel,
  input wire logic [1:0] deinst_chan,
  input wire logic cursor_enable,
  output logic install_mode,
  output logic deinstall_menu,
  output logic [1:0] hint,
  output logic [3:0] message,
  output logic [1:0] msg_chan,
  output logic submeter_indicator,
  output logic [3:0] chan_used,
  output logic [3:0] capture_clear,
  output mbind_short_id_t [3:0] chan_id
);
  typedef enum logic [2:0] {ST_IDLE, ST_LIST, ST_WAIT_IR, ST_WAIT_NR, ST_DONE, ST_DEINST} st_t;

  logic btn_s1_ff, btn_s2_ff, btn_prev_ff;
  logic [31:0] hold_ff;
  logic [31:0] nores_ff;
  logic [36:0] idle_ff;
  logic [31:0] blink_cnt_ff;
  logic blink_ff;
  st_t st_ff;
  logic [1:0] sel_chan_ff;
  logic [3:0] used_ff;
  mbind_short_id_t [3:0] id_ff;
  logic [3:0] clr_ff;
  logic [3:0] msg_ff;
  logic [1:0] hint_ff;
  logic ind_ff;

  function automatic logic [1:0] first_free(input logic [3:0] u);
    logic [1:0] r;
    r = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (!u[i]) r = 2'(i);
    end
    return r;
  endfunction

  wire release_ev = btn_prev_ff && !btn_s2_ff;
  wire held_esc = hold_ff >= (ENTER_CYC << 1);
  wire held_enter = hold_ff >= ENTER_CYC;
  wire mbind_press_t press = !release_ev ? MBIND_PR_NONE :
                             held_esc ? MBIND_PR_XLONG :
                             held_enter ? MBIND_PR_LONG : MBIND_PR_SHORT;
  wire any_free = ~&used_ff;
  wire any_used = |used_ff;
  wire [1:0] free_ch = first_free(used_ff);
  wire in_inst = st_ff inside {ST_LIST, ST_WAIT_IR, ST_WAIT_NR, ST_DONE};
  wire activity = btn_s2_ff || display_touch;
  wire timeout = in_inst && idle_ff >= TIMEOUT_CYC - 37'h1;
  // no bind on a cycle that also leaves installation mode
  wire do_bind = !timeout &&
                 ((st_ff == ST_WAIT_NR && snd_nr && press != MBIND_PR_XLONG) ||
                  (st_ff == ST_LIST && press == MBIND_PR_LONG && cand.valid &&
                   !cand.bidir && !cand.bound_elsewhere));
  wire do_tool = tool_install && any_free && !in_inst;
  wire [3:0] set_vec = (do_bind || do_tool) ? (4'h1 << free_ch) : 4'h0;
  wire do_deinst = st_ff == ST_DEINST && deinst_sel && used_ff[deinst_chan];
  wire [3:0] clr_vec = (do_deinst ? (4'h1 << deinst_chan) : 4'h0) |
                       (tool_uninstall ? (4'h1 << tool_chan) : 4'h0);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      btn_s1_ff <= 1'b0;
      btn_s2_ff <= 1'b0;
      btn_prev_ff <= 1'b0;
      hold_ff <= 32'h0;
    end else if (clk_en) begin
      btn_s1_ff <= bind_button;
      btn_s2_ff <= btn_s1_ff;
      btn_prev_ff <= btn_s2_ff;
      hold_ff <= btn_s2_ff ? (held_esc ? hold_ff : hold_ff + 32'h1) : 32'h0;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      idle_ff <= 37'h0;
      blink_cnt_ff <= 32'h0;
      blink_ff <= 1'b0;
    end else if (clk_en) begin
      idle_ff <= (activity || !in_inst) ? 37'h0 : idle_ff + 37'h1;
      blink_cnt_ff <= (blink_cnt_ff >= BLINK_CYC - 32'h1) ? 32'h0 : blink_cnt_ff + 32'h1;
      if (blink_cnt_ff >= BLINK_CYC - 32'h1) blink_ff <= !blink_ff;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= ST_IDLE;
      sel_chan_ff <= 2'h0;
      msg_ff <= `MBIND_MSG_NONE;
      nores_ff <= 32'h0;
    end else if (clk_en) begin
      if (nores_ff != 32'h0) nores_ff <= nores_ff - 32'h1;
      // countdown ends only its own message, never a later one
      if (nores_ff == 32'h1 && msg_ff == `MBIND_MSG_NORES) msg_ff <= `MBIND_MSG_NONE;
      if (timeout) begin
        st_ff <= ST_IDLE;
        msg_ff <= `MBIND_MSG_NONE;
      end else begin
        case (st_ff)
          ST_IDLE: begin
            if (press == MBIND_PR_SHORT && any_free) begin
              st_ff <= ST_LIST;
              msg_ff <= `MBIND_MSG_LIST;
            end else if (press == MBIND_PR_SHORT) begin
              msg_ff <= `MBIND_MSG_NORES;
              nores_ff <= NORES_CYC;
            end else if (press == MBIND_PR_XLONG && any_used) begin
              st_ff <= ST_DEINST;
              msg_ff <= `MBIND_MSG_DEINST;
            end
          end
          ST_LIST: begin
            if (press == MBIND_PR_XLONG) begin
              st_ff <= ST_IDLE;
              msg_ff <= `MBIND_MSG_NONE;
            end else if (press == MBIND_PR_LONG && cand.valid) begin
              if (cand.bound_elsewhere) begin
                st_ff <= ST_DONE;
                msg_ff <= `MBIND_MSG_BOUND;
              end else if (cand.bidir) begin
                st_ff <= ST_WAIT_IR;
                msg_ff <= `MBIND_MSG_BIND;
              end else begin
                st_ff <= ST_DONE;
                sel_chan_ff <= free_ch;
                msg_ff <= `MBIND_MSG_CHAN;
              end
            end
          end
          ST_WAIT_IR, ST_WAIT_NR: begin
            if (press == MBIND_PR_XLONG) begin
              st_ff <= ST_IDLE;
              msg_ff <= `MBIND_MSG_NONE;
            end else if (st_ff == ST_WAIT_IR && snd_ir) begin
              st_ff <= ST_WAIT_NR;
            end else if (st_ff == ST_WAIT_NR && snd_nr) begin
              st_ff <= ST_DONE;
              sel_chan_ff <= free_ch;
              msg_ff <= `MBIND_MSG_CHAN;
            end
          end
          ST_DONE: begin
            if (press == MBIND_PR_SHORT || press == MBIND_PR_XLONG) begin
              st_ff <= ST_IDLE;
              msg_ff <= `MBIND_MSG_NONE;
            end
          end
          ST_DEINST: begin
            if (press == MBIND_PR_XLONG || !any_used) begin
              st_ff <= ST_IDLE;
              msg_ff <= `MBIND_MSG_NONE;
            end
          end
          default: st_ff <= ST_IDLE;
        endcase
      end
    end
  end

  // channel table; tool id loaded on install
  generate
    for (genvar c = 0; c < `MBIND_NCHAN; c++) begin : g_chan
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          used_ff[c] <= 1'b0;
          id_ff[c] <= '0;
          clr_ff[c] <= 1'b0;
        end else if (clk_en) begin
          clr_ff[c] <= clr_vec[c];
          if (clr_vec[c]) begin
            used_ff[c] <= 1'b0;
          end else if (set_vec[c]) begin
            used_ff[c] <= 1'b1;
            id_ff[c] <= do_tool ? tool_id : cand.id;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      hint_ff <= MBIND_HINT_NONE;
      ind_ff <= 1'b0;
    end else if (clk_en) begin
      hint_ff <= !btn_s2_ff ? MBIND_HINT_NONE : held_esc ? MBIND_HINT_ESC :
                 held_enter ? MBIND_HINT_ENTER : MBIND_HINT_NONE;
      ind_ff <= cursor_enable && (in_inst ? blink_ff : any_used);
    end
  end

  assign install_mode = in_inst;
  assign deinstall_menu = st_ff == ST_DEINST;
  assign hint = hint_ff;
  assign message = msg_ff;
  assign msg_chan = sel_chan_ff;
  assign submeter_indicator = ind_ff;
  assign chan_used = used_ff;
  assign capture_clear = clr_ff;
  assign chan_id = id_ff;

  property p_nores;
    @(posedge mclk) disable iff (!arst_n)
      (clk_en && st_ff == ST_IDLE && press == MBIND_PR_SHORT && !any_free && !timeout)
      |=> message == `MBIND_MSG_NORES;
  endproperty
  a_nores: assert property (p_nores) else $error("no-resource not shown");

  property p_max4;
    @(posedge mclk) disable iff (!arst_n) (&used_ff) |-> set_vec == 4'h0;
  endproperty
  a_max4: assert property (p_max4) else $error("bind with all channels full");

  property p_short;
    @(posedge mclk) disable iff (!arst_n)
      (clk_en && st_ff == ST_IDLE && press == MBIND_PR_SHORT && any_free) |=> install_mode;
  endproperty
  a_short: assert property (p_short) else $error("short press did not start");

  property p_xlong;
    @(posedge mclk) disable iff (!arst_n)
      (clk_en && in_inst && press == MBIND_PR_XLONG) |=> !install_mode;
  endproperty
  a_xlong: assert property (p_xlong) else $error("extra-long did not exit");

  property p_done;
    @(posedge mclk) disable iff (!arst_n)
      (clk_en && st_ff == ST_DONE && press == MBIND_PR_SHORT) |=> !install_mode;
  endproperty
  a_done: assert property (p_done) else $error("short press did not exit");

  property p_bound;
    @(posedge mclk) disable iff (!arst_n)
      (clk_en && st_ff == ST_LIST && press == MBIND_PR_LONG && cand.valid && cand.bound_elsewhere
       && !timeout) |=> message == `MBIND_MSG_BOUND && $stable(used_ff);
  endproperty
  a_bound: assert property (p_bound) else $error("bound-elsewhere device bound");

  property p_ign;
    @(posedge mclk) disable iff (!arst_n)
      (clk_en && st_ff == ST_IDLE && !any_used && press == MBIND_PR_XLONG) |=> !deinstall_menu;
  endproperty
  a_ign: assert property (p_ign) else $error("deinstall not ignored");

  property p_hide;
    @(posedge mclk) disable iff (!arst_n) !cursor_enable[*2] |-> !submeter_indicator;
  endproperty
  a_hide: assert property (p_hide) else $error("indicator shown while disabled");

  property p_clr;
    @(posedge mclk) disable iff (!arst_n)
      (clk_en && tool_uninstall) |=> capture_clear[$past(tool_chan)] && !chan_used[$past(tool_chan)];
  endproperty
  a_clr: assert property (p_clr) else $error("uninstall did not clear");

  property p_tmo;
    @(posedge mclk) disable iff (!arst_n) (clk_en && timeout) |=> !install_mode;
  endproperty
  a_tmo: assert property (p_tmo) else $error("timeout did not exit");

  property p_lit;
    @(posedge mclk) disable iff (!arst_n)
      (clk_en && cursor_enable && !in_inst && any_used) |=> submeter_indicator;
  endproperty
  a_lit: assert property (p_lit) else $error("indicator dark with device installed");

  c_bind: cover property (@(posedge mclk) disable iff (!arst_n) st_ff == ST_WAIT_NR && snd_nr);
  c_full: cover property (@(posedge mclk) disable iff (!arst_n) &used_ff);
  c_deinst: cover property (@(posedge mclk) disable iff (!arst_n) do_deinst);
endmodule

/* test/mbind_dev.sv */
// metering device and binding button model
`timescale 1ns/1ps
module mbind_dev
  import mbind_pkg::*;
(
  input wire logic mclk,
  output logic bind_button,
  output mbind_cand_t cand,
  output logic snd_ir,
  output logic snd_nr
);
  initial begin
    bind_button = 1'b0;
    cand = '0;
    snd_ir = 1'b0;
    snd_nr = 1'b0;
  end
  task automatic hold();
    @(posedge mclk);
    bind_button <= 1'b1;
  endtask
  task automatic rel();
    @(posedge mclk);
    bind_button <= 1'b0;
    repeat (8) @(posedge mclk);
    #1;
  endtask
  task automatic press(input int n);
    hold();
    repeat (n) @(posedge mclk);
    rel();
  endtask
  task automatic offer(input logic bidir, input logic bound);
    @(posedge mclk);
    // ident and codes arbitrary
    cand <= {1'b1, bidir, bound, 64'h0000_0042_0001_0103};
  endtask
  task automatic frame(input logic ir);
    @(posedge mclk);
    snd_ir <= ir;
    snd_nr <= !ir;
    @(posedge mclk);
    snd_ir <= 1'b0;
    snd_nr <= 1'b0;
    repeat (4) @(posedge mclk);
    #1;
  endtask
endmodule

/* test/mbind_ctrl_bench.sv */
// self-checking bench for the binding control
`timescale 1ns/1ps
`include "mbind_defines.svh"
module mbind_ctrl_bench
  import mbind_pkg::*;
;
  logic mclk, arst_n, clk_en, display_touch;
  logic tool_install, tool_uninstall, deinst_sel;
  logic cursor_enable;
  logic [1:0] tool_chan, deinst_chan;
  mbind_short_id_t tool_id;
  logic bind_button, snd_ir, snd_nr, install_mode, deinstall_menu, submeter_indicator;
  mbind_cand_t cand;
  logic [1:0] hint, msg_chan;
  logic [3:0] message, chan_used, capture_clear;
  mbind_short_id_t [3:0] chan_id;
  int fails = 0, total_checks = 0, cyc = 0;
  always #12.5 mclk = ~mclk;
  // short counts keep the run brief
  mbind_ctrl #(.ENTER_CYC(32'd20), .NORES_CYC(32'd20), .TIMEOUT_CYC(37'd200),
    .BLINK_CYC(32'd4)) mbind_ctrl_inst (.mclk(mclk), .arst_n(arst_n), .clk_en(clk_en),
    .bind_button(bind_button), .display_touch(display_touch), .cand(cand),
    .snd_ir(snd_ir), .snd_nr(snd_nr), .tool_install(tool_install), .tool_id(tool_id),
    .tool_uninstall(tool_uninstall), .tool_chan(tool_chan), .deinst_sel(deinst_sel),
    .deinst_chan(deinst_chan), .cursor_enable(cursor_enable),
    .install_mode(install_mode), .deinstall_menu(deinstall_menu), .hint(hint),
    .message(message), .msg_chan(msg_chan), .submeter_indicator(submeter_indicator),
    .chan_used(chan_used), .capture_clear(capture_clear), .chan_id(chan_id));
  mbind_dev mbind_dev_inst (.mclk(mclk), .bind_button(bind_button), .cand(cand),
    .snd_ir(snd_ir), .snd_nr(snd_nr));
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic t_empty();
    chk(64'({install_mode, chan_used, submeter_indicator}), 64'h0);
    mbind_dev_inst.press(50);
    chk(64'(deinstall_menu), 64'h0);
    $display("test empty done");
  endtask
  task automatic t_unidir();
    mbind_dev_inst.press(5);
    chk(64'({install_mode, message}), 64'({1'b1, `MBIND_MSG_LIST}));
    mbind_dev_inst.offer(1'b0, 1'b0);
    mbind_dev_inst.hold();
    repeat (28) @(posedge mclk);
    #1 chk(64'(hint), 64'(MBIND_HINT_ENTER));
    mbind_dev_inst.rel();
    chk(64'({message, msg_chan, chan_used}), 64'({`MBIND_MSG_CHAN, 6'h01}));
    chk(64'(hint), 64'(MBIND_HINT_NONE));
    chk(64'(chan_id[0]), 64'h0000_0042_0001_0103);
    mbind_dev_inst.press(5);
    chk(64'(install_mode), 64'h0);
    chk(64'(submeter_indicator), 64'h1);
    $display("test unidir done");
  endtask
  task automatic t_bound();
    mbind_dev_inst.press(5);
    mbind_dev_inst.offer(1'b0, 1'b1);
    mbind_dev_inst.press(30);
    chk(64'({message, chan_used}), 64'({`MBIND_MSG_BOUND, 4'h1}));
    mbind_dev_inst.hold();
    repeat (48) @(posedge mclk);
    #1 chk(64'(hint), 64'(MBIND_HINT_ESC));
    mbind_dev_inst.rel();
    chk(64'(install_mode), 64'h0);
    $display("test bound done");
  endtask
  task automatic t_bidir();
    mbind_dev_inst.press(5);
    mbind_dev_inst.offer(1'b1, 1'b0);
    mbind_dev_inst.press(30);
    chk(64'(message), 64'(`MBIND_MSG_BIND));
    mbind_dev_inst.frame(1'b1);
    mbind_dev_inst.frame(1'b0);
    chk(64'(chan_used), 64'h3);
    chk(64'(msg_chan), 64'h1);
    mbind_dev_inst.press(5);
    chk(64'(install_mode), 64'h0);
    $display("test bidir done");
  endtask
  task automatic t_tool();
    @(posedge mclk);
    tool_id <= 64'h0000_0077_0002_0304;
    tool_install <= 1'b1;
    repeat (3) @(posedge mclk);
    tool_install <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk(64'(chan_id[2]), 64'(tool_id));
    chk(64'(chan_used), 64'hF);
    mbind_dev_inst.press(5);
    chk(64'({install_mode, message}), 64'({1'b0, `MBIND_MSG_NORES}));
    repeat (14) @(posedge mclk);
    #1 chk(64'(message), 64'(`MBIND_MSG_NORES));
    @(posedge mclk);
    #1 chk(64'(message), 64'(`MBIND_MSG_NONE));
    $display("test tool done");
  endtask
  task automatic t_uninst();
    @(posedge mclk);
    tool_chan <= 2'h1;
    tool_uninstall <= 1'b1;
    @(posedge mclk);
    tool_uninstall <= 1'b0;
    #1 chk(64'(capture_clear), 64'h2);
    chk(64'(chan_used), 64'hD);
    @(posedge mclk);
    #1 chk(64'(capture_clear), 64'h0);
    $display("test uninstall done");
  endtask
  task automatic t_timeout();
    logic seen;
    logic v;
    mbind_dev_inst.press(5);
    seen = 1'b0;
    v = submeter_indicator;
    repeat (10) begin
      @(posedge mclk);
      #1 if (submeter_indicator !== v) seen = 1'b1;
    end
    chk(64'(seen), 64'h1);
    repeat (150) @(posedge mclk);
    display_touch <= 1'b1;
    @(posedge mclk);
    display_touch <= 1'b0;
    repeat (150) @(posedge mclk);
    #1 chk(64'(install_mode), 64'h1);
    repeat (80) @(posedge mclk);
    #1 chk(64'(install_mode), 64'h0);
    chk(64'(submeter_indicator), 64'h1);
    $display("test timeout done");
  endtask
  task automatic t_deinst();
    mbind_dev_inst.press(50);
    chk(64'({deinstall_menu, message}), 64'({1'b1, `MBIND_MSG_DEINST}));
    @(posedge mclk);
    deinst_chan <= 2'h0;
    deinst_sel <= 1'b1;
    @(posedge mclk);
    deinst_sel <= 1'b0;
    #1 chk(64'(capture_clear), 64'h1);
    chk(64'(chan_used), 64'hC);
    @(posedge mclk);
    cursor_enable <= 1'b0;
    repeat (3) @(posedge mclk);
    #1 chk(64'(submeter_indicator), 64'h0);
    mbind_dev_inst.press(50);
    chk(64'(deinstall_menu), 64'h0);
    $display("test deinstall done");
  endtask
  // low enable must swallow both an uninstall and a press
  task automatic t_freeze();
    @(posedge mclk);
    clk_en <= 1'b0;
    tool_chan <= 2'h2;
    tool_uninstall <= 1'b1;
    @(posedge mclk);
    tool_uninstall <= 1'b0;
    mbind_dev_inst.press(5);
    chk(64'({install_mode, chan_used}), 64'h0C);
    @(posedge mclk);
    clk_en <= 1'b1;
    mbind_dev_inst.press(5);
    chk(64'(install_mode), 64'h1);
    mbind_dev_inst.press(50);
    chk(64'(install_mode), 64'h0);
    $display("test freeze done");
  endtask
  initial begin
    mclk = 1'b0;
    arst_n = 1'b0;
    clk_en = 1'b1;
    display_touch = 1'b0;
    tool_install = 1'b0;
    tool_uninstall = 1'b0;
    deinst_sel = 1'b0;
    cursor_enable = 1'b1;
    tool_chan = 2'h0;
    deinst_chan = 2'h0;
    tool_id = '0;
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    #1;
    t_empty();
    t_unidir();
    t_bound();
    t_bidir();
    t_tool();
    t_uninst();
    t_timeout();
    t_deinst();
    t_freeze();
    stop_test();
  end
  // hang guard well above the expected run
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      stop_test();
    end
  end
endmodule
